// File: logic_cell.sv
// One configurable logic cell with LUT, carry and cascade paths, a packable
// register with clear/preset/load schemes, an emulated internal bus and an
// AXI4-Lite slave for configuration and status.
// Assumes neighbour cells and routing drive the data pins in the aclk domain.
//
// Overview of operation
// - Normal mode feeds four data inputs and carry-in into a 4-input LUT.
// - A configuration bit picks carry-in or data_in_three as one LUT input.
// - Normal mode may AND the LUT output with cascade-in onto cascade-out.
// - Local and global outputs each select LUT or register independently.
// - Packed register loads from data_in_four while LUT computes three inputs.
// - A packed register keeps clock enable, clear and preset like any other.
// - Arithmetic mode uses two 3-input LUTs for the sum and carry-out.
// - Arithmetic mode still allows the cascade chain alongside the carry chain.
// - Up/down counter has enable, clock enable, direction and data loading.
// - Counter modes load synchronously through a 2-to-1 multiplexer.
// - Counters also load asynchronously through clear and preset, no LUT used.
// - Clearable counter takes sync clear on cascade-in, ANDed with load mux.
// - Emulated bus resolves contention to low and no driver to high.
// - In the clear scheme, asynchronous clear comes from either cluster control line, by choice.
// - In load schemes, control line one loads data_in_three at once.
// - Register clear and preset are active low; unused ones are held high.
// - Six control schemes: clear, preset, both, load+clear, load+preset, load.
// - Enabled chip-wide reset overrides all; inverted registers read as preset.
// - Preset may use the clear with register input and output inverted.
// - Clear-and-preset: line one sets to one, line two clears.
// - Load-with-clear: line one drives preset and clear, line two only clear.
// - Load-with-preset: inverted register, line two presets, line one loads.
// - The register has a synchronous clock enable in all four modes.
`default_nettype none
module logic_cell
  import cell_pkg::*;
#(
  parameter int unsigned TRI_DRIVERS = 4
)(
  input  wire  logic                            aclk,
  input  wire  logic                            aresetn,
  input  wire  logic [cell_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire  logic [2:0]                      s_axi_awprot,
  input  wire  logic                            s_axi_awvalid,
  output logic                                  s_axi_awready,
  input  wire  logic [cell_pkg::AXI_DATA_W-1:0] s_axi_wdata,
  input  wire  logic [3:0]                      s_axi_wstrb,
  input  wire  logic                            s_axi_wvalid,
  output logic                                  s_axi_wready,
  output logic [1:0]                            s_axi_bresp,
  output logic                                  s_axi_bvalid,
  input  wire  logic                            s_axi_bready,
  input  wire  logic [cell_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire  logic [2:0]                      s_axi_arprot,
  input  wire  logic                            s_axi_arvalid,
  output logic                                  s_axi_arready,
  output logic [cell_pkg::AXI_DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                            s_axi_rresp,
  output logic                                  s_axi_rvalid,
  input  wire  logic                            s_axi_rready,
  input  wire  logic                            data_in_one,
  input  wire  logic                            data_in_two,
  input  wire  logic                            data_in_three,
  input  wire  logic                            data_in_four,
  input  wire  logic                            carry_in,
  input  wire  logic                            cascade_in,
  input  wire  logic                            cluster_ctrl_one,
  input  wire  logic                            cluster_ctrl_two,
  input  wire  logic                            cell_clk_en,
  input  wire  logic                            chip_reset_n,
  input  wire  logic [TRI_DRIVERS-1:0]          tri_drv_data,
  input  wire  logic [TRI_DRIVERS-1:0]          tri_drv_oe,
  output logic                                  carry_out,
  output logic                                  cascade_out,
  output logic                                  local_out,
  output logic                                  global_out,
  output logic                                  tri_bus_out
);

  // ---------------------------------------------------------------------
  // Register file state
  logic [CFG_W-1:0]      cfg_ff;
  logic [LUT_W-1:0]      lut_ff;
  logic                  q_ff;

  // AXI write channel state
  logic                  aw_held_ff;
  logic [AXI_ADDR_W-1:0] awaddr_ff;
  logic                  w_held_ff;
  logic [AXI_DATA_W-1:0] wdata_ff;
  logic [3:0]            wstrb_ff;
  logic                  bvalid_ff;
  logic [1:0]            bresp_ff;

  // AXI read channel state
  logic                  rvalid_ff;
  logic [AXI_DATA_W-1:0] rdata_ff;
  logic [1:0]            rresp_ff;

  // ---------------------------------------------------------------------
  // Configuration fields
  mode_t   mode;
  scheme_t scheme;
  wire logic carry_sel  = cfg_ff[CARRY_SEL_POS];
  wire logic casc_en    = cfg_ff[CASC_EN_POS];
  wire logic pack_en    = cfg_ff[PACK_EN_POS];
  wire logic local_sel  = cfg_ff[LOCAL_SEL_POS];
  wire logic global_sel = cfg_ff[GLOBAL_SEL_POS];
  wire logic clr_sel    = cfg_ff[CLR_SEL_POS];
  wire logic pre_inv    = cfg_ff[PRE_INV_POS];
  wire logic chip_rst_en = cfg_ff[CHIP_RST_POS];

  assign mode   = mode_t'(cfg_ff[MODE_POS +: 2]);
  assign scheme = scheme_t'(cfg_ff[SCHEME_POS +: 3]);

  // ---------------------------------------------------------------------
  // Asynchronous control: register clear/preset are active low
  logic clr_n;
  logic pre_n;
  logic inv_reg;

  wire logic clr_line  = clr_sel ? cluster_ctrl_two : cluster_ctrl_one;
  wire logic load_hi   = cluster_ctrl_one & data_in_three;
  wire logic load_lo   = cluster_ctrl_one & ~data_in_three;

  always_comb
  begin
    clr_n   = 1'b1;
    pre_n   = 1'b1;
    inv_reg = 1'b0;
    case (scheme)
      SCH_CLEAR:
      begin
        clr_n = ~clr_line;
      end
      SCH_PRESET:
      begin
        if (pre_inv)
        begin
          // Inverted register frees data_in_three for the operating mode
          clr_n   = ~cluster_ctrl_one;
          inv_reg = 1'b1;
        end
        else
        begin
          pre_n = ~cluster_ctrl_one;
        end
      end
      SCH_CLR_PRE:
      begin
        // Load input is taken as held high, so line one sets to one
        pre_n = ~cluster_ctrl_one;
        clr_n = ~cluster_ctrl_two;
      end
      SCH_LOAD_CLR:
      begin
        pre_n = ~load_hi;
        clr_n = ~(load_lo | cluster_ctrl_two);
      end
      SCH_LOAD_PRE:
      begin
        // The source of data_in_three arrives inverted to match
        inv_reg = 1'b1;
        pre_n   = ~load_hi;
        clr_n   = ~(load_lo | cluster_ctrl_two);
      end
      SCH_LOAD:
      begin
        pre_n = ~load_hi;
        clr_n = ~load_lo;
      end
      default:
      begin
        clr_n = 1'b1;
        pre_n = 1'b1;
      end
    endcase
  end

  wire logic chip_rst = chip_rst_en & ~chip_reset_n;

  // Stored value seen immediately while a control is asserted, so a load
  // or clear shows at the outputs without waiting for the clock edge.
  logic stored_now;

  always_comb
  begin
    if (chip_rst)
      stored_now = Q_RST;
    else if (!clr_n)
      stored_now = 1'b0;
    else if (!pre_n)
      stored_now = 1'b1;
    else
      stored_now = q_ff;
  end

  // Output inversion makes an inverted register read as preset after reset
  wire logic q_out = stored_now ^ inv_reg;

  // ---------------------------------------------------------------------
  // Normal mode LUT
  wire logic       lut_in3  = carry_sel ? carry_in : data_in_three;
  wire logic       lut_in4  = pack_en ? 1'b0 : data_in_four;
  wire logic [3:0] norm_idx = {lut_in4, lut_in3, data_in_two, data_in_one};
  wire logic       norm_lut = lut_ff[norm_idx];
  wire logic       norm_d   = pack_en ? data_in_four : norm_lut;

  // Arithmetic mode: low half of the mask is the sum, high half the carry
  wire logic [2:0] arith_idx = {carry_in, data_in_two, data_in_one};
  wire logic       arith_sum = lut_ff[{1'b0, arith_idx}];
  wire logic       arith_cy  = lut_ff[{1'b1, arith_idx}];

  // Counter modes: data_in_two enables counting, data_in_four selects load
  // of data_in_three, cascade-in carries direction or the sync clear.
  wire logic count_up  = (mode == MODE_UPDOWN) ? cascade_in : 1'b1;
  wire logic sclr_n    = (mode == MODE_CLRCNT) ? cascade_in : 1'b1;
  wire logic cnt_lut   = q_out ^ (data_in_two & carry_in);
  wire logic cnt_carry = carry_in & (count_up ? q_out : ~q_out);
  wire logic cnt_mux   = data_in_four ? data_in_three : cnt_lut;
  wire logic cnt_d     = cnt_mux & sclr_n;

  // Mode selection
  logic comb_val;
  logic d_sel;
  logic carry_val;
  logic casc_src;

  always_comb
  begin
    comb_val  = 1'b0;
    d_sel     = 1'b0;
    carry_val = 1'b0;
    casc_src  = 1'b0;
    case (mode)
      MODE_NORMAL:
      begin
        comb_val  = norm_lut;
        d_sel     = norm_d;
        casc_src  = norm_lut;
      end
      MODE_ARITH:
      begin
        comb_val  = arith_sum;
        d_sel     = arith_sum;
        carry_val = arith_cy;
        casc_src  = arith_sum;
      end
      MODE_UPDOWN, MODE_CLRCNT:
      begin
        comb_val  = cnt_d;
        d_sel     = cnt_d;
        carry_val = cnt_carry;
        casc_src  = 1'b1;
      end
      default:
      begin
        comb_val  = 1'b0;
      end
    endcase
  end

  // Counters use cascade-in for control, so their cascade-out stays neutral
  wire logic casc_on = casc_en & ((mode == MODE_NORMAL) | (mode == MODE_ARITH));

  assign cascade_out = casc_on ? (casc_src & cascade_in) : casc_src;
  assign carry_out   = carry_val;
  assign local_out   = local_sel ? q_out : comb_val;
  assign global_out  = global_sel ? q_out : comb_val;

  // ---------------------------------------------------------------------
  // Cell register: same controls whether packed or not
  wire logic d_store = d_sel ^ inv_reg;
  logic nxt_q;

  always_comb
  begin
    if (chip_rst | ~clr_n | ~pre_n)
      nxt_q = stored_now;
    else if (cell_clk_en)
      nxt_q = d_store;
    else
      nxt_q = q_ff;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q_ff <= Q_RST;
    else
      q_ff <= nxt_q;
  end

  // ---------------------------------------------------------------------
  // Emulated internal bus
  logic [TRI_DRIVERS-1:0] drv_term;
  logic [TRI_DRIVERS-1:0] other_en;

  genvar gi;
  generate
    for (gi = 0; gi < TRI_DRIVERS; gi++)
    begin : g_drv
      assign drv_term[gi] = tri_drv_oe[gi] & tri_drv_data[gi];
      assign other_en[gi] = tri_drv_oe[gi] & |(tri_drv_oe & ~(TRI_DRIVERS'(1) << gi));
    end
  endgenerate

  wire logic tri_any   = |tri_drv_oe;
  wire logic tri_multi = |other_en;

  assign tri_bus_out = !tri_any ? 1'b1 : (tri_multi ? 1'b0 : |drv_term);

  // ---------------------------------------------------------------------
  // AXI4-Lite write path: address and data taken in either order
  assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_held_ff & ~bvalid_ff;

  wire logic                  aw_take = s_axi_awvalid & s_axi_awready;
  wire logic                  w_take  = s_axi_wvalid & s_axi_wready;
  wire logic                  wr_go   = (aw_held_ff | aw_take) & (w_held_ff | w_take);
  wire logic [AXI_ADDR_W-1:0] wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr;
  wire logic [AXI_DATA_W-1:0] wr_data = w_held_ff ? wdata_ff : s_axi_wdata;
  wire logic [3:0]            wr_strb = w_held_ff ? wstrb_ff : s_axi_wstrb;

  wire logic wr_cfg  = {wr_addr[3:2], 2'b00} == CFG_OFF;
  wire logic wr_lut  = {wr_addr[3:2], 2'b00} == LUT_OFF;
  wire logic wr_stat = {wr_addr[3:2], 2'b00} == STATUS_OFF;

  function automatic logic [AXI_DATA_W-1:0] merge(input logic [AXI_DATA_W-1:0] old,
                                                   input logic [AXI_DATA_W-1:0] val,
                                                   input logic [3:0]            strb);
    logic [AXI_DATA_W-1:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        res[8*b +: 8] = val[8*b +: 8];
    return res;
  endfunction

  wire logic [AXI_DATA_W-1:0] cfg_wide = merge({{(AXI_DATA_W-CFG_W){1'b0}}, cfg_ff},
                                               wr_data, wr_strb);
  wire logic [AXI_DATA_W-1:0] lut_wide = merge({{(AXI_DATA_W-LUT_W){1'b0}}, lut_ff},
                                               wr_data, wr_strb);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_ff <= 1'b0;
      awaddr_ff  <= '0;
      w_held_ff  <= 1'b0;
      wdata_ff   <= '0;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      cfg_ff     <= CFG_RST;
      lut_ff     <= LUT_RST;
    end
    else
    begin
      if (aw_take && !wr_go)
      begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end
      if (w_take && !wr_go)
      begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= (wr_cfg | wr_lut | wr_stat) ? RESP_OKAY : RESP_SLVERR;
        if (wr_cfg)
          cfg_ff <= cfg_wide[CFG_W-1:0];
        if (wr_lut)
          lut_ff <= lut_wide[LUT_W-1:0];
      end
      else if (s_axi_bready)
      begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // ---------------------------------------------------------------------
  // AXI4-Lite read path: one read at a time, answered the next cycle
  assign s_axi_arready = ~rvalid_ff;

  wire logic ar_take = s_axi_arvalid & s_axi_arready;
  wire logic rd_cfg  = {s_axi_araddr[3:2], 2'b00} == CFG_OFF;
  wire logic rd_lut  = {s_axi_araddr[3:2], 2'b00} == LUT_OFF;
  wire logic rd_stat = {s_axi_araddr[3:2], 2'b00} == STATUS_OFF;

  wire logic [ST_W-1:0] status_val = {pre_n, clr_n, tri_bus_out, global_out, local_out,
                                      cascade_out, carry_out, comb_val, q_out};

  wire logic [AXI_DATA_W-1:0] rd_val =
    rd_cfg  ? {{(AXI_DATA_W-CFG_W){1'b0}}, cfg_ff} :
    rd_lut  ? {{(AXI_DATA_W-LUT_W){1'b0}}, lut_ff} :
    rd_stat ? {{(AXI_DATA_W-ST_W){1'b0}}, status_val} : '0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_val;
      rresp_ff  <= (rd_cfg | rd_lut | rd_stat) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

endmodule
`default_nettype wire

// File: cell_pkg.sv
// Package for the configurable logic cell: register map, field positions,
// reset values and the enumerations of operating modes and control schemes.
// Assumes an AXI4-Lite master with 32-bit data and a 4-bit byte address.
`default_nettype none
package cell_pkg;

  localparam int unsigned AXI_ADDR_W = 4;
  localparam int unsigned AXI_DATA_W = 32;

  // Register byte offsets
  localparam logic [3:0]  CFG_OFF    = 4'h0;
  localparam logic [3:0]  LUT_OFF    = 4'h4;
  localparam logic [3:0]  STATUS_OFF = 4'h8;

  // Configuration register fields
  localparam int unsigned MODE_POS      = 0;
  localparam int unsigned CARRY_SEL_POS = 2;
  localparam int unsigned CASC_EN_POS   = 3;
  localparam int unsigned PACK_EN_POS   = 4;
  localparam int unsigned LOCAL_SEL_POS = 5;
  localparam int unsigned GLOBAL_SEL_POS = 6;
  localparam int unsigned SCHEME_POS    = 7;
  localparam int unsigned CLR_SEL_POS   = 10;
  localparam int unsigned PRE_INV_POS   = 11;
  localparam int unsigned CHIP_RST_POS  = 12;
  localparam int unsigned CFG_W         = 13;
  localparam int unsigned LUT_W         = 16;

  // Status register fields
  localparam int unsigned ST_Q_POS      = 0;
  localparam int unsigned ST_COMB_POS   = 1;
  localparam int unsigned ST_CARRY_POS  = 2;
  localparam int unsigned ST_CASC_POS   = 3;
  localparam int unsigned ST_LOCAL_POS  = 4;
  localparam int unsigned ST_GLOBAL_POS = 5;
  localparam int unsigned ST_TRI_POS    = 6;
  localparam int unsigned ST_CLRN_POS   = 7;
  localparam int unsigned ST_PREN_POS   = 8;
  localparam int unsigned ST_W          = 9;

  // Reset values
  localparam logic [CFG_W-1:0] CFG_RST  = 13'h0000;
  localparam logic [LUT_W-1:0] LUT_RST  = 16'h0000;
  localparam logic             Q_RST    = 1'b0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_ARITH,
    MODE_UPDOWN,
    MODE_CLRCNT
  } mode_t;

  typedef enum logic [2:0] {
    SCH_CLEAR,
    SCH_PRESET,
    SCH_CLR_PRE,
    SCH_LOAD_CLR,
    SCH_LOAD_PRE,
    SCH_LOAD
  } scheme_t;

endpackage
`default_nettype wire

// File: cell_assertions.sv
// Checker for the logic cell: bus handshakes and emulated bus resolution.
// Assumes it is bound into logic_cell and sees only that module's ports.
`default_nettype none
module cell_assertions #(
  parameter int unsigned TRI_DRIVERS = 4
)(
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire logic                   s_axi_awvalid,
  input wire logic                   s_axi_awready,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_bready,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic                   s_axi_rvalid,
  input wire logic                   s_axi_rready,
  input wire logic [TRI_DRIVERS-1:0] tri_drv_data,
  input wire logic [TRI_DRIVERS-1:0] tri_drv_oe,
  input wire logic                   tri_bus_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_axi_bvalid) else $error("write answer late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  // Contention and float are resolved to fixed levels, never passed on
  AST_TRI_NONE: assert property (tri_drv_oe == '0 |-> tri_bus_out)
    else $error("idle bus not high");
  AST_TRI_MULTI: assert property ($countones(tri_drv_oe) > 1 |-> !tri_bus_out)
    else $error("contended bus not low");
  AST_TRI_ONE: assert property ($onehot(tri_drv_oe) |->
    tri_bus_out == |(tri_drv_oe & tri_drv_data))
    else $error("single driver not passed");
endmodule
bind logic_cell cell_assertions #(.TRI_DRIVERS(TRI_DRIVERS)) u_chk (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .tri_drv_data, .tri_drv_oe, .tri_bus_out);
`default_nettype wire

// File: chain_neighbour.sv
// Neighbouring cell on the chain side: presents carry and cascade levels.
// Assumes the bench commands those levels at rising clock edges.
`default_nettype none
module chain_neighbour (
  input  wire logic carry_cmd,
  input  wire logic casc_cmd,
  output logic      carry_in,
  output logic      cascade_in
);
  // Combinational, as a real neighbour's chain outputs are
  assign carry_in   = carry_cmd;
  assign cascade_in = casc_cmd;
endmodule
`default_nettype wire

// File: tb.sv
// Bench for the logic cell: register access, cell modes, control schemes.
// Assumes cell_pkg, the neighbour model and the checker are compiled first.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cell_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, bready = 1'b1, rready = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [3:0] awaddr = '0, araddr = '0, toe = '0, tdat = '0;
  logic [31:0] wdata = '0;
  // Cell pins: d1..d4, carry, cascade, enable, ctrl one, ctrl two, chip reset
  logic [9:0] pins = '0;
  logic awready, wready, bvalid, arready, rvalid, carry_in, cascade_in;
  logic carry_out, cascade_out, local_out, global_out, tri_bus_out;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int bad_count = 0, cmp_count = 0;
  logic_cell #(.TRI_DRIVERS(4)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .data_in_one(pins[0]),
    .data_in_two(pins[1]), .data_in_three(pins[2]), .data_in_four(pins[3]),
    .carry_in(carry_in), .cascade_in(cascade_in), .cell_clk_en(pins[6]),
    .cluster_ctrl_one(pins[7]), .cluster_ctrl_two(pins[8]), .chip_reset_n(!pins[9]),
    .tri_drv_data(tdat), .tri_drv_oe(toe), .carry_out(carry_out),
    .cascade_out(cascade_out), .local_out(local_out), .global_out(global_out),
    .tri_bus_out(tri_bus_out));
  chain_neighbour nb (.carry_cmd(pins[4]), .casc_cmd(pins[5]), .carry_in(carry_in),
    .cascade_in(cascade_in));
  always #25 aclk = ~aclk;
  task automatic stop_test;
    if (bad_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // Ready is sampled at the falling edge, where it is settled for the next rise
  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic at, wt, bt;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    do
    begin
      @(negedge aclk);
      at = awvalid & awready; wt = wvalid & wready; bt = bvalid; r = bresp;
      @(posedge aclk);
      if (at) awvalid <= 1'b0;
      if (wt) wvalid <= 1'b0;
    end while (!bt);
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic t, rv;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1;
    do
    begin
      @(negedge aclk);
      t = arvalid & arready; rv = rvalid; d = rdata; r = rresp;
      @(posedge aclk);
      if (t) arvalid <= 1'b0;
    end while (!rv);
  endtask
  task automatic cfg(input logic [31:0] c, input logic [31:0] l);
    logic [1:0] r;
    axw(LUT_OFF, l, r);
    axw(CFG_OFF, c, r);
    chk(r, RESP_OKAY);
  endtask
  task automatic drv(input logic [9:0] v);
    @(posedge aclk);
    pins <= v;
    @(negedge aclk);
  endtask
  task automatic sq(input logic [9:0] v, input logic e);
    drv(v);
    chk(global_out, e);
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axr(CFG_OFF, d, r); chk(d, CFG_RST);
    rready <= 1'b0;
    axr(LUT_OFF, d, r); chk(d, LUT_RST);
    // Late ready: the answer has to stand until it is accepted
    rready <= 1'b1;
    @(negedge aclk); chk(rvalid, 1);
    axr(4'hc, d, r); chk(r, RESP_SLVERR);
    bready <= 1'b0;
    axw(4'hc, 32'h1, r); chk(r, RESP_SLVERR);
    bready <= 1'b1;
    @(negedge aclk); chk(bvalid, 1);
  endtask
  task automatic t_norm;
    logic [15:0] l;
    logic x;
    l = 16'hc3a5;
    for (int s = 0; s < 2; s++)
    begin
      cfg(32'h8 | (s << 2), l);
      for (int i = 0; i < 16; i++)
      begin
        x = i[2] ^ s[0];
        drv({4'h0, i[0] ^ i[3], ~x, i[3], x, i[1:0]});
        chk(local_out, l[i]);
        chk(cascade_out, l[i] & (i[0] ^ i[3]));
      end
    end
  endtask
  task automatic t_pack;
    cfg(32'h050, 32'h00a5);
    drv(10'h040);
    drv(10'h00f); chk(global_out, 0); chk(local_out, 1);
    drv(10'h04f); chk(global_out, 0);
    drv(10'h04f); chk(global_out, 1);
    sq(10'h0cf, 0);
  endtask
  task automatic t_arith;
    int s;
    cfg(32'h349, 32'he896);
    for (int i = 0; i < 8; i++)
    begin
      s = i[0] + i[1] + i[2];
      drv({4'h0, i[1], i[2], 2'b00, i[1:0]});
      chk(local_out, s[0]); chk(carry_out, s[1]);
      chk(cascade_out, s[0] & i[1]);
    end
  endtask
  task automatic t_cnt;
    cfg(32'h362, 32'h0);
    drv(10'h06c);
    drv(10'h072); chk(global_out, 1); chk(carry_out, 1); chk(local_out, 1);
    drv(10'h052); chk(global_out, 0); chk(carry_out, 1);
    cfg(32'h343, 32'h0);
    drv(10'h06c);
    sq(10'h04c, 1);
    sq(10'h04c, 0);
  endtask
  task automatic t_sch;
    logic [31:0] d;
    logic [1:0] r;
    cfg(32'h040, 32'hffff); drv(10'h040);
    sq(10'h000, 1);
    sq(10'h080, 0);
    cfg(32'h440, 32'hffff); drv(10'h040);
    sq(10'h080, 1); sq(10'h100, 0);
    cfg(32'h140, 32'hffff);
    sq(10'h104, 0); sq(10'h004, 0); sq(10'h084, 1); sq(10'h004, 1);
    cfg(32'h1c0, 32'hffff);
    sq(10'h080, 0); sq(10'h084, 1); sq(10'h104, 0);
    cfg(32'h240, 32'hffff);
    sq(10'h100, 1); sq(10'h084, 0); sq(10'h080, 1);
    cfg(32'h12c0, 32'hffff);
    sq(10'h084, 1);
    sq(10'h284, 0); sq(10'h004, 0);
    cfg(32'h1240, 32'hffff);
    sq(10'h200, 1);
    cfg(32'h0c0, 32'hffff);
    sq(10'h000, 0); sq(10'h080, 1);
    cfg(32'h8c0, 32'hffff);
    sq(10'h080, 1);
    axr(STATUS_OFF, d, r); chk(d, 32'h17b);
  endtask
  task automatic t_tri;
    for (int i = 0; i < 32; i++)
    begin
      @(posedge aclk);
      toe <= i[3:0]; tdat <= {4{i[4]}} ^ 4'h5;
      @(negedge aclk);
      chk(tri_bus_out, toe == 0 ? 1 : $countones(toe) > 1 ? 0 : |(toe & tdat));
    end
  endtask
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs; t_norm; t_pack; t_arith; t_cnt; t_sch; t_tri;
    stop_test;
  end
  // Generous bound: the whole sequence needs well under two thousand cycles
  initial
  begin
    repeat (5000) @(posedge aclk);
    bad_count++;
    stop_test;
  end
endmodule
`default_nettype wire
